// *** hw/reset_strap_consts.vh ***
// Purpose: constants for the reset strap latch and status indicator block
// Assumes: included by bare name from hw/
// Notes: offsets are APB byte addresses, one aligned 32-bit word each
`ifndef RESET_STRAP_CONSTS_VH
`define RESET_STRAP_CONSTS_VH

// register byte offsets
`define REG_STATUS 12'h000
`define REG_CONTROL 12'h004
`define REG_MODE 12'h008

// control register fields and reset values
`define CTL_SUSP_LED_BIT 0
`define CTL_LED_EN_BIT 1
`define CTL_RESET 2'h3

// status register field positions
`define ST_CODE_LSB 0
`define ST_STRAP_EN_BIT 3
`define ST_FIXED_LSB 4
`define ST_PORTS_LSB 6
`define ST_SELF_PWR_BIT 9
`define ST_RUN_BIT 10

// mode register field positions
`define MD_ADDR_LSB 0
`define MD_SMB_BIT 8
`define MD_USB_LED_BIT 9
`define MD_GANG_PWR_BIT 10
`define MD_GANG_OCS_BIT 11

// configuration-select codes
`define CODE_DEFAULT 3'h0
`define CODE_SMBUS 3'h1
`define CODE_BUS_PWR 3'h2
`define CODE_DYN_USB 3'h5
`define CODE_GANGED 3'h7
`define SMBUS_ADDR 7'h2c

// fixed-port strap decode, ports 3..1
`define FIXED_NONE 3'h0
`define FIXED_P1 3'h1
`define FIXED_P12 3'h3
`define FIXED_P123 3'h7

// timing: least external reset pulse and clock period
`define RST_MIN_NS 1000
`define CLK_PERIOD_NS 20
`define RST_MIN_CYC ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W 6

`endif

// *** hw/reset_strap_latch_and_status_leds.v ***
// Purpose: latch configuration straps at reset release, drive status LEDs, sense self power
// Assumes: clk is the hub reference clock domain; pins arrive asynchronously
// Notes: APB slave for status and control; shared pins are two-way with active-low enables
//
// Functional notes
// - latch three config-select pins at reset release
// - missing third select pin reads as zero
// - high-speed LED polarity follows select bit one
// - high-speed LED asserted only at high speed
// - power-on reset holds logic until supplies stable
// - suspend LED asserted when configured, not suspended
// - sense low means bus powered, high self
// - fixed-port straps used only when straps enabled
// - decode fixed-port strap into ports one to three
// - suspend LED polarity from fixed-port strap code
// - reference clock from crystal or external clock
// - code 001 selects SMBus slave, address 0101100
// - code 111 gives defaults, ganged power, USB LEDs
`timescale 1ns/1ns
`include "reset_strap_consts.vh"

module reset_strap_latch_and_status_leds #(
   parameter HAS_SELECT_BIT2 = 1
) (
   input wire clk,
   input wire sys_rst,
   input wire clkEn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // board-side pins
   input wire resetPinN,
   input wire supplyStable,
   input wire config_select_bit0In,
   output reg config_select_bit0Out,
   output reg config_select_bit0OeN,
   input wire config_select_bit1In,
   output reg upstream_high_speed_ledOut,
   output reg upstream_high_speed_ledOeN,
   input wire config_select_bit2In,
   input wire active_suspend_ledIn,
   output reg active_suspend_ledOut,
   output reg active_suspend_ledOeN,
   input wire fixed_port_strap_bit1In,
   output reg fixed_port_strap_bit1Out,
   output reg fixed_port_strap_bit1OeN,
   // hub core side
   input wire hubHighSpeed,
   input wire hubConfigured,
   input wire hubSuspended,
   output reg hubInReset,
   output reg [2:0] configCode,
   output reg strapsEnabled,
   output reg [3:1] fixedPorts,
   output reg selfPowered,
   output reg smbusSlaveEn,
   output reg [6:0] smbusAddress,
   output reg usbLedMode,
   output reg gangedPower,
   output reg gangedOcs
);

   localparam NSYNC = 7;
   localparam integer RST_MIN_I = `RST_MIN_CYC;
   localparam [`RST_CNT_W-1:0] RST_MIN = RST_MIN_I[`RST_CNT_W-1:0];

   // sequencer states, binary coded
   localparam [1:0] ST_HOLD = 2'h0;
   localparam [1:0] ST_CAPTURE = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;

   // gathered asynchronous inputs: pin levels and the supply-stable flag
   wire [NSYNC-1:0] rawIn = {fixed_port_strap_bit1In, active_suspend_ledIn, config_select_bit2In,
      config_select_bit1In, config_select_bit0In, supplyStable, resetPinN};
   reg [NSYNC-1:0] syncA_ff;
   reg [NSYNC-1:0] syncB_ff;

   // two-flop synchronisers, one per pin; stage A feeds only stage B.
   // limitation: a pin change shorter than one clock may be missed;
   // straps are static and leds slow, so nothing here depends on short pulses.
   // the stages clear to zero, which reads as reset pin low and supplies bad,
   // so the block starts held until both inputs have been seen good
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always @(posedge clk) begin
            if (sys_rst) begin
               syncA_ff[gi] <= 1'b0;
               syncB_ff[gi] <= 1'b0;
            end else if (clkEn) begin
               syncA_ff[gi] <= rawIn[gi];
               syncB_ff[gi] <= syncA_ff[gi];
            end
         end
      end
   endgenerate

   wire rstPinS = syncB_ff[0];
   wire supplyS = syncB_ff[1];
   wire [2:0] selS = {(HAS_SELECT_BIT2 != 0) & syncB_ff[4], syncB_ff[3], syncB_ff[2]};
   wire suspPinS = syncB_ff[5];
   wire fixed1S = syncB_ff[6];

   reg [`RST_CNT_W-1:0] lowCnt_ff;
   reg extRstHeld_ff;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [1:0] fixedCode_ff;
   reg [1:0] ctl_ff;

   // reset sources, in order of precedence:
   //   sys_rst clears everything and starts in the held state
   //   a pin pulse held long enough re-enters the held state
   //   a supply dip forces the held state for as long as it lasts
   // capture happens once on the way out of hold, never while running.
   // external reset counts only after a full minimum-width low pulse,
   // so short glitches on the pin cannot restart strap capture
   always @(posedge clk) begin
      if (sys_rst) begin
         lowCnt_ff <= {`RST_CNT_W{1'b0}};
         extRstHeld_ff <= 1'b1;
      end else if (clkEn) begin
         if (rstPinS) begin
            lowCnt_ff <= {`RST_CNT_W{1'b0}};
            extRstHeld_ff <= 1'b0;
         end else if (lowCnt_ff < RST_MIN - 1'b1) begin
            lowCnt_ff <= lowCnt_ff + 1'b1;
         end else begin
            extRstHeld_ff <= 1'b1;
         end
      end
   end

   // internal reset: pin reset or supplies not yet stable
   wire inReset = extRstHeld_ff | ~supplyS;

   // sequencer: hold, one capture cycle, then run until the next reset
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_HOLD: begin
            if (!inReset) nxt_state = ST_CAPTURE;
         end
         ST_CAPTURE: begin
            nxt_state = inReset ? ST_HOLD : ST_RUN;
         end
         ST_RUN: begin
            if (inReset) nxt_state = ST_HOLD;
         end
         default: begin
            nxt_state = ST_HOLD;
         end
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) state_ff <= ST_HOLD;
      else if (clkEn) state_ff <= nxt_state;
   end

   wire capture = (state_ff == ST_CAPTURE);
   wire running = (state_ff == ST_RUN);
   wire selStrapsOn = (selS == `CODE_DEFAULT) | (selS == `CODE_BUS_PWR);

   // codes that disable straps force the fixed-port code to 00, which
   // also leaves the suspend led active high and every port removable;
   // the pins are still sampled, their levels are simply not used.
   // strap capture; values are written only in the capture cycle
   // and therefore stay fixed while the pins serve other roles
   always @(posedge clk) begin
      if (sys_rst) begin
         configCode <= 3'h0;
         strapsEnabled <= 1'b0;
         fixedCode_ff <= 2'h0;
         fixedPorts <= `FIXED_NONE;
         smbusSlaveEn <= 1'b0;
         smbusAddress <= 7'h0;
         usbLedMode <= 1'b0;
         gangedPower <= 1'b0;
         gangedOcs <= 1'b0;
      end else if (clkEn && capture) begin
         configCode <= selS;
         strapsEnabled <= selStrapsOn;
         fixedCode_ff <= selStrapsOn ? {fixed1S, suspPinS} : 2'h0;
         case (selStrapsOn ? {fixed1S, suspPinS} : 2'h0)
            2'h0: fixedPorts <= `FIXED_NONE;
            2'h1: fixedPorts <= `FIXED_P1;
            2'h2: fixedPorts <= `FIXED_P12;
            default: fixedPorts <= `FIXED_P123;
         endcase
         smbusSlaveEn <= (selS == `CODE_SMBUS);
         smbusAddress <= (selS == `CODE_SMBUS) ? `SMBUS_ADDR : 7'h0;
         usbLedMode <= (selS == `CODE_GANGED) | (selS == `CODE_BUS_PWR) | (selS == `CODE_DYN_USB);
         gangedPower <= (selS == `CODE_GANGED);
         gangedOcs <= (selS == `CODE_GANGED);
      end
   end

   // led polarity is fixed at capture: hub status is xor-ed with the latched
   // bit, so a board wired for active-low leds needs no software help.
   // leds stay released unless enabled, so a board without leds sees only
   // its strap resistors; the suspend pin doubles as the self-power sense.
   // pin roles; every pin floats as input until capture is done.
   // the reference clock is whatever drives clk (crystal or external source)
   always @(posedge clk) begin
      if (sys_rst) begin
         hubInReset <= 1'b1;
         config_select_bit0Out <= 1'b0;
         config_select_bit0OeN <= 1'b1;
         fixed_port_strap_bit1Out <= 1'b0;
         fixed_port_strap_bit1OeN <= 1'b1;
         upstream_high_speed_ledOut <= 1'b0;
         upstream_high_speed_ledOeN <= 1'b1;
         active_suspend_ledOut <= 1'b0;
         active_suspend_ledOeN <= 1'b1;
         selfPowered <= 1'b0;
      end else if (clkEn) begin
         hubInReset <= ~running;
         // serial lines stay released; the serial engine lives outside this block
         config_select_bit0Out <= 1'b0;
         config_select_bit0OeN <= 1'b1;
         fixed_port_strap_bit1Out <= 1'b0;
         fixed_port_strap_bit1OeN <= 1'b1;
         upstream_high_speed_ledOeN <= ~(running & ctl_ff[`CTL_LED_EN_BIT]);
         upstream_high_speed_ledOut <= running & (hubHighSpeed ^ configCode[1]);
         active_suspend_ledOeN <= ~(running & ctl_ff[`CTL_SUSP_LED_BIT] & ctl_ff[`CTL_LED_EN_BIT]);
         active_suspend_ledOut <= running & ((hubConfigured & ~hubSuspended) ^ fixedCode_ff[0]);
         // sense follows the pin only while it is released as an input
         if (running && !ctl_ff[`CTL_SUSP_LED_BIT]) selfPowered <= suspPinS;
      end
   end

   // register map, one aligned word each:
   //   status (ro): code, straps enabled, fixed code, fixed ports, self power, run
   //   control (rw): bit 0 suspend pin as led (1) or sense (0), bit 1 led enable
   //   mode (ro): serial address, serial slave, usb leds, ganged power and sense
   // writes to read-only words are dropped without an error; unmapped words
   // answer with an error and have no side effect.
   // a control write lands only at the access edge, so an aborted setup
   // can never change the pin roles.
   // apb slave: one wait-free access phase, answer registered
   wire setup = psel & ~penable & ~pready;
   wire access = psel & penable & pready;

   always @(posedge clk) begin
      if (sys_rst) begin
         ctl_ff <= `CTL_RESET;
      end else if (clkEn && access && pwrite && !pslverr && paddr == `REG_CONTROL) begin
         ctl_ff <= pwdata[1:0];
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (clkEn) begin
         pready <= setup;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         if (setup) begin
            case (paddr)
               `REG_STATUS: begin
                  if (!pwrite) begin
                     prdata[`ST_CODE_LSB +: 3] <= configCode;
                     prdata[`ST_STRAP_EN_BIT] <= strapsEnabled;
                     prdata[`ST_FIXED_LSB +: 2] <= fixedCode_ff;
                     prdata[`ST_PORTS_LSB +: 3] <= fixedPorts;
                     prdata[`ST_SELF_PWR_BIT] <= selfPowered;
                     prdata[`ST_RUN_BIT] <= running;
                  end
               end
               `REG_CONTROL: begin
                  if (!pwrite) prdata[1:0] <= ctl_ff;
               end
               `REG_MODE: begin
                  if (!pwrite) begin
                     prdata[`MD_ADDR_LSB +: 7] <= smbusAddress;
                     prdata[`MD_SMB_BIT] <= smbusSlaveEn;
                     prdata[`MD_USB_LED_BIT] <= usbLedMode;
                     prdata[`MD_GANG_PWR_BIT] <= gangedPower;
                     prdata[`MD_GANG_OCS_BIT] <= gangedOcs;
                  end
               end
               default: begin
                  pslverr <= 1'b1; // unmapped address
               end
            endcase
         end
      end
   end

endmodule

// *** tb/strap_monitor.sv ***
// Purpose: port checks for the strap latch block
// Assumes: one clock domain; bound to every instance
// Notes: led checks allow one cycle of registered latency
`timescale 1ns/1ns
`include "reset_strap_consts.vh"
module strap_monitor (
   input wire clk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire hubHighSpeed,
   input wire hubConfigured,
   input wire hubSuspended,
   input wire hubInReset,
   input wire upstream_high_speed_ledOut,
   input wire upstream_high_speed_ledOeN,
   input wire active_suspend_ledOut,
   input wire active_suspend_ledOeN,
   input wire [2:0] configCode,
   input wire [3:1] fixedPorts,
   input wire strapsEnabled,
   input wire smbusSlaveEn,
   input wire [6:0] smbusAddress,
   input wire gangedPower,
   input wire gangedOcs
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // a setup phase is answered by exactly one ready pulse
   sequence s_setup; psel && !penable && !pready; endsequence
   sequence s_pulse; pready ##1 !pready; endsequence
   a_ready_pulse: assert property (s_setup |=> s_pulse) else $error("ready pulse");
   a_hs_polarity: assert property (!upstream_high_speed_ledOeN |->
      upstream_high_speed_ledOut == ($past(hubHighSpeed) ^ configCode[1])) else $error("hs led");
   a_susp_polarity: assert property (!active_suspend_ledOeN |->
      active_suspend_ledOut == (($past(hubConfigured) && !$past(hubSuspended)) ^ (^fixedPorts)))
      else $error("suspend led");
   a_straps_hold: assert property (!hubInReset && !$past(hubInReset) |->
      $stable({configCode, fixedPorts, strapsEnabled})) else $error("straps moved");
   a_smbus_mode: assert property (!hubInReset |-> smbusSlaveEn == (configCode == `CODE_SMBUS) &&
      (!smbusSlaveEn || smbusAddress == `SMBUS_ADDR)) else $error("smbus mode");
   a_ganged_mode: assert property (!hubInReset |->
      gangedPower == (configCode == `CODE_GANGED) && gangedOcs == gangedPower) else $error("ganged");
   a_fixed_decode: assert property (!hubInReset |->
      (fixedPorts inside {3'h0, 3'h1, 3'h3, 3'h7}) && (strapsEnabled || fixedPorts == 3'h0))
      else $error("fixed ports");
   a_dark_reset: assert property (hubInReset |->
      upstream_high_speed_ledOeN && active_suspend_ledOeN) else $error("led driven in reset");
endmodule
bind reset_strap_latch_and_status_leds strap_monitor strap_monitor_i (.*);

// *** tb/strap_board.sv ***
// Purpose: strap resistors, reset source and led loads
// Assumes: a released shared pin rests at its strap level
// Notes: the reset pulse is a fixed 60 cycles
`timescale 1ns/1ns
module strap_board (
   input wire clk,
   input wire pulse,
   input wire [4:0] strap,
   input wire upstream_high_speed_ledOut,
   input wire upstream_high_speed_ledOeN,
   input wire active_suspend_ledOut,
   input wire active_suspend_ledOeN,
   output wire resetPinN,
   output wire hsPin,
   output wire suspPin
);
   reg [6:0] lowCnt_ff = 7'h00;
   // 60 cycles at 50 MHz stays above the 1 us minimum
   always @(posedge clk) begin
      if (pulse)
         lowCnt_ff <= 7'h3c;
      else if (lowCnt_ff != 7'h00)
         lowCnt_ff <= lowCnt_ff - 7'h01;
   end
   assign resetPinN = lowCnt_ff == 7'h00;
   // released pins fall back to the resistor level
   assign hsPin = upstream_high_speed_ledOeN ? strap[1] : upstream_high_speed_ledOut;
   assign suspPin = active_suspend_ledOeN ? strap[3] : active_suspend_ledOut;
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the strap latch block
// Assumes: clkEn held high
// Notes: apb results are checked against a queue of notes
`timescale 1ns/1ns
`include "reset_strap_consts.vh"
module tb_top;
   localparam logic [32:0] allBits = 33'h1ffffffff;
   localparam logic [32:0] errBit = 33'h100000000;
   logic clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pulse = 1'h0;
   logic supplyStable = 1'h1, hubHighSpeed = 1'h0, hubConfigured = 1'h0, hubSuspended = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rnd = 32'hc55a;
   logic [4:0] strap = 5'h00;
   logic [2:0] configCode, configCodeNoSel2;
   logic sel0Out, sel0OeN, fix1Out, fix1OeN;
   logic [3:1] fixedPorts;
   logic [6:0] smbusAddress;
   logic pready, pslverr, resetPinN, hubInReset, selfPowered, hsPin, suspPin;
   logic strapsEnabled, smbusSlaveEn, usbLedMode, gangedPower, gangedOcs;
   logic upstream_high_speed_ledOut, upstream_high_speed_ledOeN, active_suspend_ledOut, active_suspend_ledOeN;
   logic [32:0] expQ[$], mskQ[$];
   int failures = 0, num_checks = 0;
   always #10 clk = ~clk;
   reset_strap_latch_and_status_leds reset_strap_latch_and_status_leds_i (.*, .clkEn(1'h1),
      .config_select_bit0In(strap[0]), .config_select_bit0Out(sel0Out), .config_select_bit0OeN(sel0OeN),
      .config_select_bit1In(hsPin), .config_select_bit2In(strap[2]), .active_suspend_ledIn(suspPin),
      .fixed_port_strap_bit1In(strap[4]), .fixed_port_strap_bit1Out(fix1Out), .fixed_port_strap_bit1OeN(fix1OeN));
   // package without the third select pin, fed by the same board
   reset_strap_latch_and_status_leds #(.HAS_SELECT_BIT2(0)) reset_strap_latch_and_status_leds_i2 (.*,
      .clkEn(1'h1), .config_select_bit0In(strap[0]), .config_select_bit1In(hsPin),
      .config_select_bit2In(strap[2]), .active_suspend_ledIn(suspPin), .fixed_port_strap_bit1In(strap[4]),
      .configCode(configCodeNoSel2), .prdata(), .pready(), .pslverr(), .config_select_bit0Out(),
      .config_select_bit0OeN(), .upstream_high_speed_ledOut(), .upstream_high_speed_ledOeN(),
      .active_suspend_ledOut(), .active_suspend_ledOeN(), .fixed_port_strap_bit1Out(),
      .fixed_port_strap_bit1OeN(), .hubInReset(), .strapsEnabled(), .fixedPorts(), .selfPowered(),
      .smbusSlaveEn(), .smbusAddress(), .usbLedMode(), .gangedPower(), .gangedOcs());
   strap_board strap_board_i (.*);
   task chk(input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // one transfer; the request holds until ready is seen at an edge, or 20 edges pass
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
      int n;
      n = 0;
      expQ.push_back(e & m);
      mskQ.push_back(m);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1 && ++n < 20);
      if (pready !== 1'h1) failures++; // no answer counts as a mismatch
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // pin reset, or a supply dip when por is set
   task pinReset(input logic por);
      int n;
      n = 0;
      if (por)
         supplyStable <= 1'h0;
      else
         pulse <= 1'h1;
      @(posedge clk);
      pulse <= 1'h0;
      repeat (80) @(posedge clk);
      supplyStable <= 1'h1;
      while (hubInReset !== 1'h0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk(hubInReset, 1'h0);
   endtask
   // oldest note against each finished transfer
   always @(posedge clk)
      if (psel && penable && pready === 1'h1)
         chk({pslverr, prdata} & mskQ.pop_front(), expQ.pop_front());
   initial begin
      logic [2:0] code;
      logic [1:0] f;
      logic en;
      repeat (16) @(posedge clk);
      sys_rst <= 1'h0;
      apb(1'h0, `REG_CONTROL, 32'h0, {31'h0, `CTL_RESET}, allBits);
      apb(1'h0, 12'h00c, 32'h0, errBit, errBit);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         code = i[2:0];
         strap <= {rnd[1:0], code};
         pinReset(i == 5);
         chk(configCodeNoSel2, {1'h0, code[1:0]});
         chk({sel0Out, sel0OeN, fix1Out, fix1OeN}, 4'h5);
         en = code == `CODE_DEFAULT || code == `CODE_BUS_PWR;
         f = en ? rnd[1:0] : 2'h0;
         apb(1'h1, `REG_CONTROL, 32'h3, 33'h0, errBit);
         apb(1'h1, `REG_STATUS, 32'hffffffff, 33'h0, errBit);
         repeat (2) begin
            apb(1'h0, `REG_STATUS, 32'h0, {23'h1, 1'h0, &f, f[1], |f, f, en, code}, 33'h1fffffdff);
            apb(1'h0, `REG_MODE, 32'h0, {21'h0, {2{code == `CODE_GANGED}}, code == 3'h2 || code == 3'h5 ||
               code == 3'h7, code == `CODE_SMBUS, 1'h0, `SMBUS_ADDR},
               code == `CODE_SMBUS ? allBits : 33'h1ffffff80);
            strap <= ~strap;
         end
         hubHighSpeed <= rnd[2];
         hubConfigured <= rnd[3];
         hubSuspended <= rnd[4];
         repeat (3) @(posedge clk);
         chk(upstream_high_speed_ledOut, rnd[2] ^ code[1]);
         chk(active_suspend_ledOut, (rnd[3] & ~rnd[4]) ^ f[0]);
         chk(upstream_high_speed_ledOeN | active_suspend_ledOeN, 1'h0);
         $display("test %0d done", i);
      end
      apb(1'h1, `REG_CONTROL, 32'h2, 33'h0, errBit);
      for (int j = 0; j < 2; j++) begin
         strap[3] <= j[0];
         repeat (6) @(posedge clk);
         chk(selfPowered, j[0]);
      end
      $display("test sense done");
      end_sim;
   end
   // a hang beyond nearly six times the run length ends the run
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      end_sim;
   end
endmodule
